// ---- verilog/emas_pkg.sv ----
/*
 * constants, field layout and state type of the external memory access sequencer.
 * assumes core_clk ticks once per timing phase: two ticks make one bus cycle.
 */
//------------------------------------------------------------
// Overview of operation
// - split transaction per bank width and lanes
// - address bit one from byte half; wb1 is a0 on 8-bit banks
// - lane write strobes follow valid bytes
// - output enable rises at end after capture
// - reads keep write strobes idle; a0 stays
// - writes keep output enable high
// - 8-bit writes float upper data lines
// - edges beyond duration give undefined strobes
// - coinciding edges past phase zero leave strobe unchanged
// - accesses of one transaction run back to back
// - one pending transaction, no idle gaps
// - read then write waits turnaround cycles
// - one dead cycle on bank switch
// - nonzero drive delay from each bank's own config
// - wait sampled at midpoint when enabled and duration is at least four cycles
// - odd duration samples next rising edge
// - wait high freezes access until low
// - edges after high sample are held off
// - only selected bank chip/output enable
// - strobe edges timed in half-cycle phases
// - width select clear 16-bit, set 8-bit
//------------------------------------------------------------
package emas_pkg;
    localparam int          NumBanks      = 4;
    localparam int          PhasesPerCyc  = 2;
    // register offsets
    localparam logic [7:0]  CfgBaseOfs    = 8'h00;
    localparam logic [7:0]  StatusOfs     = 8'h10;
    // bank configuration word layout
    localparam int          WaitEnBit     = 0;
    localparam int          DriveDlyLsb   = 1;
    localparam int          WidthBit      = 4;
    localparam int          DurLsb        = 5;
    localparam int          RelLsb        = 9;
    localparam int          Ce1Lsb        = 11;
    localparam int          Ce2Lsb        = 15;
    localparam int          Oe1Lsb        = 19;
    localparam int          Wb1Lsb        = 23;
    localparam int          Wb2Lsb        = 27;
    localparam logic [31:0] CfgResetVal   = 32'h1480054b;
    // status word layout
    localparam int          StBusyBit     = 0;
    localparam int          StStallBit    = 1;
    localparam int          StPendBit     = 2;
    // timing
    localparam logic [3:0]  MinWaitCycles = 4'h4;
    localparam logic [5:0]  BankSwitchPh  = 6'h02;
    typedef enum logic [1:0] {StIdle, StGap, StAccess} emas_state_type;
endpackage

// ---- verilog/emas_sequencer.sv ----
/*
 * external memory access sequencer: splits 32-bit transactions into 8/16-bit
 * bank accesses and places the chip, output and byte strobes in phases.
 * assumes core_clk runs at the phase rate, the memory bus keeps request fields
 * stable while reqValid is high and reqReady low, and config writes are sane.
 */
`timescale 1ns/1ps
`default_nettype none
module emas_sequencer (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // configuration port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // internal memory bus
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [31:2] reqAddr,
    input  wire logic [3:0]  reqBytes,
    input  wire logic [31:0] reqWdata,
    output logic             reqReady,
    output logic             rspValid,
    output logic      [31:0] rspRdata,
    // external memory pins
    output logic      [19:2] memAddrHigh,
    output logic             addrBitOne,
    output logic      [3:0]  bankChipEnableN,
    output logic      [3:0]  readOutputEnableN,
    output logic             lowLaneWriteStrobeN,
    output logic             highLaneWriteStrobeN,
    input  wire logic [15:0] dataLinesIn,
    output logic      [15:0] dataLinesOut,
    output logic             lowerDataLinesOe,
    output logic             upperDataLinesOe,
    input  wire logic        extWaitIn
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed {
        emas_pkg::emas_state_type st;
        logic [3:0][31:0] cfg;
        logic [5:0]  ph;
        logic [5:0]  gap;
        logic        stall;
        logic [1:0]  waitSync;
        logic [15:0] dinS1;
        logic [15:0] dinS2;
        logic        pendValid;
        logic        pendWrite;
        logic [31:2] pendAddr;
        logic [3:0]  pendBytes;
        logic [31:0] pendWdata;
        logic        curWrite;
        logic [1:0]  curBank;
        logic [3:0]  curRem;
        logic [3:0]  curLanes;
        logic [31:0] curWdata;
        logic [31:0] rdBuf;
        logic        usedBus;
        logic        lastRead;
        logic [1:0]  lastBank;
        logic [31:0] regRdata;
        logic        reqReady;
        logic        rspValid;
        logic [31:0] rspRdata;
        logic [19:2] memAddrHigh;
        logic        addrBitOne;
        logic [3:0]  ceN;
        logic [3:0]  oeN;
        logic        wb0N;
        logic        wb1N;
        logic [15:0] dout;
        logic        loOe;
        logic        hiOe;
    } emas_regs_type;

    emas_regs_type q;
    emas_regs_type d;

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // bank number from the signed quarter of the address space
    function automatic logic [1:0] bankOf(input logic [31:2] a);
        bankOf = {~a[31], a[30]};
    endfunction

    // byte lanes of the next access of a transaction
    function automatic logic [3:0] lanesOf(input logic [3:0] m, input logic w8);
        lanesOf = 4'h0;
        if (w8) begin
            lanesOf = m & (~m + 4'h1);                     // lowest valid byte
        end else if (m[1:0] != 2'h0) begin
            lanesOf = m & 4'h3;                            // low half-word
        end else begin
            lanesOf = m & 4'hc;
        end
    endfunction

    // dead phases needed before the pending transaction may start
    function automatic logic [5:0] gapOf(input emas_regs_type r);
        logic [5:0] turn;
        logic [5:0] sw;
        logic [1:0] rel;
        rel  = r.cfg[bankOf(r.pendAddr)][emas_pkg::RelLsb +: 2];
        turn = (r.usedBus && r.lastRead && r.pendWrite) ? {3'h0, rel, 1'b0} : 6'h00;
        sw   = (r.usedBus && r.lastBank != bankOf(r.pendAddr)) ?
               emas_pkg::BankSwitchPh : 6'h00;
        gapOf = (turn > sw) ? turn : sw;
    endfunction

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    logic [31:0] c;          // config of the current bank
    logic [31:0] cn;         // config of the bank of the next access
    logic        w8;
    logic [5:0]  lenPh;
    logic [5:0]  p;
    logic [5:0]  ceRise;
    logic [5:0]  wbRise;
    logic [5:0]  waitPh;
    logic        waitOn;
    logic        launch;
    logic        fromPend;
    logic        same;
    logic [3:0]  m;
    logic [3:0]  ln;
    logic [1:0]  bk;
    logic        wr;
    logic        nw8;
    logic [31:0] wd;

    always_comb begin
        d        = q;
        launch   = 1'b0;
        fromPend = 1'b0;
        same     = 1'b0;
        d.rspValid = 1'b0;
        d.regRdata = 32'h0;
        // two-flop synchronisers for pins
        d.waitSync = {q.waitSync[0], extWaitIn};
        d.dinS1    = dataLinesIn;
        d.dinS2    = q.dinS1;

        // configuration port
        if (regWr && regAddr[7:4] == emas_pkg::CfgBaseOfs[7:4] && regAddr[1:0] == 2'h0) begin
            d.cfg[regAddr[3:2]] = regWdata;
        end
        if (regRd) begin
            if (regAddr[7:4] == emas_pkg::CfgBaseOfs[7:4] && regAddr[1:0] == 2'h0) begin
                d.regRdata = q.cfg[regAddr[3:2]];
            end else if (regAddr == emas_pkg::StatusOfs) begin
                d.regRdata[emas_pkg::StBusyBit]  = (q.st != emas_pkg::StIdle);
                d.regRdata[emas_pkg::StStallBit] = q.stall;
                d.regRdata[emas_pkg::StPendBit]  = q.pendValid;
            end
        end

        // timing of the current access, all in phases
        c      = q.cfg[q.curBank];
        w8     = c[emas_pkg::WidthBit];
        lenPh  = {1'b0, c[emas_pkg::DurLsb +: 4], 1'b0};
        if (lenPh < 6'(emas_pkg::PhasesPerCyc)) begin
            lenPh = 6'(emas_pkg::PhasesPerCyc);
        end
        p      = q.ph + 6'h01;                                                   // next phase
        ceRise = lenPh - {2'h0, c[emas_pkg::Ce2Lsb +: 4]};
        wbRise = lenPh - {2'h0, c[emas_pkg::Wb2Lsb +: 4]};
        // midpoint, or the rising edge after it for odd durations
        waitPh = {2'h0, c[emas_pkg::DurLsb +: 4]} + {5'h0, c[emas_pkg::DurLsb]};
        waitOn = c[emas_pkg::WaitEnBit] &&
                 (c[emas_pkg::DurLsb +: 4] >= emas_pkg::MinWaitCycles);

        unique case (q.st)
            emas_pkg::StIdle: begin  // holding register is looked at below
            end
            emas_pkg::StGap: begin
                if (q.gap == 6'h00) begin
                    launch   = 1'b1;
                    fromPend = 1'b1;
                end else begin
                    d.gap = q.gap - 6'h01;
                end
            end
            emas_pkg::StAccess: begin
                if (q.stall) begin
                    // frozen: only resample, strobe edges held off
                    if (!q.waitSync[1]) begin
                        d.stall = 1'b0;
                    end
                end else if (waitOn && q.ph == waitPh && q.waitSync[1]) begin
                    // wait high: phase and the edges due next are held
                    d.stall = 1'b1;
                end else begin
                    // edges one tick ahead so pins move at their phase
                    if (c[emas_pkg::Ce1Lsb +: 4] != ceRise[3:0] || ceRise[5:4] != 2'h0) begin
                        if (p == {2'h0, c[emas_pkg::Ce1Lsb +: 4]}) begin
                            d.ceN[q.curBank] = 1'b0;
                        end
                        if (p == ceRise) begin
                            d.ceN[q.curBank] = 1'b1;
                        end
                    end
                    if (!q.curWrite && p == {2'h0, c[emas_pkg::Oe1Lsb +: 4]}) begin
                        d.oeN[q.curBank] = 1'b0;
                    end
                    if (q.curWrite && c[emas_pkg::Wb1Lsb +: 4] != wbRise[3:0]) begin
                        if (p == {2'h0, c[emas_pkg::Wb1Lsb +: 4]}) begin
                            d.wb0N = ~(w8 | q.curLanes[0] | q.curLanes[2]);
                            if (!w8) begin
                                d.wb1N = ~(q.curLanes[1] | q.curLanes[3]);
                            end
                        end
                        if (p == wbRise) begin
                            d.wb0N = 1'b1;
                            if (!w8) begin
                                d.wb1N = 1'b1;
                            end
                        end
                    end
                    // write data drive after the launch delay from the current bank's config
                    if (q.curWrite && p == {3'h0, c[emas_pkg::DriveDlyLsb +: 3]}) begin
                        d.loOe = 1'b1;
                        d.hiOe = ~w8;
                    end
                    if (p == lenPh) begin
                        // end of access: capture read data, then release strobes
                        for (int i = 0; i < 4; i++) begin
                            if (!q.curWrite && q.curLanes[i]) begin
                                d.rdBuf[8*i +: 8] = (w8 || i % 2 == 0) ?
                                                    q.dinS2[7:0] : q.dinS2[15:8];
                            end
                        end
                        d.oeN      = 4'hf;
                        d.ceN      = 4'hf;
                        d.wb0N     = 1'b1;
                        d.wb1N     = w8 ? q.wb1N : 1'b1;
                        d.loOe     = 1'b0;
                        d.hiOe     = 1'b0;
                        d.curRem   = q.curRem & ~q.curLanes;
                        d.stall    = 1'b0;
                        d.usedBus  = 1'b1;
                        d.lastRead = ~q.curWrite;
                        d.lastBank = q.curBank;
                        if ((q.curRem & ~q.curLanes) != 4'h0) begin
                            launch = 1'b1;
                            same   = 1'b1;
                        end else begin
                            d.rspValid = 1'b1;
                            d.rspRdata = d.rdBuf;
                            d.st       = emas_pkg::StIdle;
                        end
                    end else begin
                        d.ph = p;
                    end
                end
            end
            default: begin
                d.st = emas_pkg::StIdle;
            end
        endcase
        // next transaction from the holding register, after any dead phases
        if (d.st == emas_pkg::StIdle && q.pendValid) begin
            if (gapOf(d) == 6'h00) begin
                launch   = 1'b1;
                fromPend = 1'b1;
            end else begin
                d.st  = emas_pkg::StGap;
                d.gap = gapOf(d) - 6'h01;
            end
        end

        // start of an access, either the next piece or a new transaction
        m   = same ? (q.curRem & ~q.curLanes) : q.pendBytes;
        bk  = same ? q.curBank : bankOf(q.pendAddr);
        wr  = same ? q.curWrite : q.pendWrite;
        wd  = same ? q.curWdata : q.pendWdata;
        cn  = q.cfg[bk];
        nw8 = cn[emas_pkg::WidthBit];
        ln  = lanesOf(m, nw8);
        if (launch) begin
            d.st       = emas_pkg::StAccess;
            d.ph       = 6'h00;
            d.curLanes = ln;
            if (fromPend) begin
                d.pendValid   = 1'b0;
                d.curRem      = q.pendBytes;
                d.curBank     = bk;
                d.curWrite    = wr;
                d.curWdata    = wd;
                d.rdBuf       = 32'h0;
                d.memAddrHigh = q.pendAddr[19:2];
            end
            d.addrBitOne = ln[2] | ln[3];
            // 8-bit banks use the upper lane strobe as address bit zero
            d.wb1N = nw8 ? (ln[1] | ln[3]) : 1'b1;
            if (nw8) begin
                d.dout = {8'h0, ln[3] ? wd[31:24] : ln[2] ? wd[23:16] :
                                ln[1] ? wd[15:8] : wd[7:0]};
            end else begin
                d.dout = ln[3] | ln[2] ? wd[31:16] : wd[15:0];
            end
            // phase-zero edges; a strobe low at the end stays low
            if (cn[emas_pkg::Ce1Lsb +: 4] == 4'h0) begin
                d.ceN[bk] = 1'b0;
            end
            if (!wr && cn[emas_pkg::Oe1Lsb +: 4] == 4'h0) begin
                d.oeN[bk] = 1'b0;
            end
            if (wr && cn[emas_pkg::DriveDlyLsb +: 3] == 3'h0) begin
                d.loOe = 1'b1;
                d.hiOe = ~nw8;
            end
            if (wr && cn[emas_pkg::Wb1Lsb +: 4] == 4'h0) begin
                d.wb0N = ~(nw8 | ln[0] | ln[2]);
                d.wb1N = nw8 ? d.wb1N : ~(ln[1] | ln[3]);
            end
        end

        // one-entry holding register for the next transaction
        if (reqValid && !q.pendValid) begin
            d.pendValid = 1'b1;
            d.pendWrite = reqWrite;
            d.pendAddr  = reqAddr;
            d.pendBytes = reqBytes;
            d.pendWdata = reqWdata;
        end
        d.reqReady = ~d.pendValid;
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    // state update with idle pins after reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q            <= '0;
            q.st         <= emas_pkg::StIdle;
            q.cfg        <= {emas_pkg::NumBanks{emas_pkg::CfgResetVal}};
            q.reqReady   <= 1'b1;
            q.addrBitOne <= 1'b1;
            q.ceN        <= 4'hf;
            q.oeN        <= 4'hf;
            q.wb0N       <= 1'b1;
            q.wb1N       <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    assign regRdata             = q.regRdata;
    assign reqReady             = q.reqReady;
    assign rspValid             = q.rspValid;
    assign rspRdata             = q.rspRdata;
    assign memAddrHigh          = q.memAddrHigh;
    assign addrBitOne           = q.addrBitOne;
    assign bankChipEnableN      = q.ceN;
    assign readOutputEnableN    = q.oeN;
    assign lowLaneWriteStrobeN  = q.wb0N;
    assign highLaneWriteStrobeN = q.wb1N;
    assign dataLinesOut         = q.dout;
    assign lowerDataLinesOe     = q.loOe;
    assign upperDataLinesOe     = q.hiOe;
endmodule
`default_nettype wire

// ---- verilog/emas_sequencer_dummy_unused.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/emas_sequencer_props.sv ----
/* pin-level checker of the access sequencer, bound to emas_sequencer.
   assumes one phase clock and the default bank timing of the bench. */
`timescale 1ns/1ps
`default_nettype none
module emas_sequencer_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // memory bus
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        rspValid,
    // memory pins
    input wire logic [19:2] memAddrHigh,
    input wire logic        addrBitOne,
    input wire logic [3:0]  bankChipEnableN,
    input wire logic [3:0]  readOutputEnableN,
    input wire logic        lowLaneWriteStrobeN,
    input wire logic        lowerDataLinesOe,
    input wire logic        upperDataLinesOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_one_ce; $onehot0(~bankChipEnableN); endproperty
    a_one_ce: assert property (p_one_ce) else $error("two chip enables low");
    property p_oe_rd; !(&readOutputEnableN) |-> lowLaneWriteStrobeN; endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("write strobe in read");
    property p_no_drv; lowerDataLinesOe |-> &readOutputEnableN; endproperty
    a_no_drv: assert property (p_no_drv) else $error("output enable in write");
    property p_wb_data; !lowLaneWriteStrobeN |-> lowerDataLinesOe; endproperty
    a_wb_data: assert property (p_wb_data) else $error("strobe without data");
    property p_hi_drv; upperDataLinesOe |-> lowerDataLinesOe; endproperty
    a_hi_drv: assert property (p_hi_drv) else $error("upper lines alone");
    property p_hold; !lowLaneWriteStrobeN && !$past(lowLaneWriteStrobeN)
        |-> $stable(addrBitOne) && $stable(memAddrHigh); endproperty
    a_hold: assert property (p_hold) else $error("address moved in strobe");
    property p_take; reqValid && reqReady |=> !reqReady; endproperty
    a_take: assert property (p_take) else $error("holding slot not taken");
    property p_pulse; rspValid |=> !rspValid; endproperty
    a_pulse: assert property (p_pulse) else $error("response too long");
    property p_done; reqValid && reqReady |-> ##[1:1000] rspValid; endproperty
    a_done: assert property (p_done) else $error("no response");
    property p_rst; disable iff (1'b0) srst |=> &bankChipEnableN && &readOutputEnableN
        && lowLaneWriteStrobeN && addrBitOne && !lowerDataLinesOe; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle in reset");
endmodule
bind emas_sequencer emas_sequencer_props emas_sequencer_props_i (.*);
`default_nettype wire

// ---- verif/emas_mem_model.sv ----
/* sram-like part on the four banks, with a wait pulse after chip select.
   assumes the bench tells which banks are byte wide. */
`timescale 1ns/1ps
`default_nettype none
module emas_mem_model (
    // clock and pins
    input  wire logic        core_clk,
    input  wire logic [19:2] memAddrHigh,
    input  wire logic        addrBitOne,
    input  wire logic [3:0]  bankChipEnableN,
    input  wire logic [3:0]  readOutputEnableN,
    input  wire logic        lowLaneWriteStrobeN,
    input  wire logic        highLaneWriteStrobeN,
    input  wire logic [15:0] dataLinesOut,
    output logic      [15:0] dataLinesIn,
    output logic             extWaitIn,
    // bench controls
    input  wire logic [3:0]  byteWide,
    input  wire logic [7:0]  stallTicks
);
    logic [7:0] mem [256];
    logic [7:0] waitCnt = 8'h00;
    logic       flip    = 1'b0;
    logic [3:0] ceLast  = 4'hf;
    logic [1:0] bk;
    logic [5:0] row;
    initial foreach (mem[i]) mem[i] = 8'h00;
    // selected bank, read drive; released lines toggle each tick
    always_comb begin
        bk = 2'h0;
        for (int i = 0; i < 4; i++) if (!bankChipEnableN[i]) bk = 2'(i);
        row = {bk, memAddrHigh[5:2]};
        if (readOutputEnableN[bk] !== 1'b0) dataLinesIn = {16{flip}};
        else if (byteWide[bk]) dataLinesIn = {{8{~flip}}, mem[{row, addrBitOne, highLaneWriteStrobeN}]};
        else dataLinesIn = {mem[{row, addrBitOne, 1'b1}], mem[{row, addrBitOne, 1'b0}]};
    end
    // lane writes, and wait held a bounded time after chip select falls
    always @(posedge core_clk) begin
        flip <= ~flip;
        ceLast <= bankChipEnableN;
        if (|(ceLast & ~bankChipEnableN)) waitCnt <= stallTicks;
        else if (waitCnt != 8'h00) waitCnt <= waitCnt - 8'h01;
        if (!bankChipEnableN[bk] && !lowLaneWriteStrobeN)
            mem[{row, addrBitOne, byteWide[bk] & highLaneWriteStrobeN}] <= dataLinesOut[7:0];
        if (!bankChipEnableN[bk] && !highLaneWriteStrobeN && !byteWide[bk])
            mem[{row, addrBitOne, 1'b1}] <= dataLinesOut[15:8];
    end
    assign extWaitIn = waitCnt != 8'h00;
endmodule
`default_nettype wire

// ---- verif/ext_memory_access_sequencer_tb.sv ----
/* self-checking bench: bank setup, all lane masks on three banks, wait.
   assumes the memory model keeps bytes in lane order per bank. */
`timescale 1ns/1ps
`default_nettype none
module ext_memory_access_sequencer_tb;
    logic core_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqReady, rspValid;
    logic [7:0] regAddr = 8'h00, stallTicks = 8'h00;
    logic [31:0] regWdata = 32'h0, reqWdata = 32'h0, regRdata, rspRdata;
    logic [31:2] reqAddr = '0;
    logic [3:0] reqBytes = 4'h1, byteWide = 4'h2;
    wire logic [19:2] memAddrHigh;
    wire logic [15:0] dataLinesIn, dataLinesOut;
    wire logic [3:0] bankChipEnableN, readOutputEnableN;
    wire logic addrBitOne, lowLaneWriteStrobeN, highLaneWriteStrobeN;
    wire logic lowerDataLinesOe, upperDataLinesOe, extWaitIn;
    logic [32:0] expQ[$];
    logic [7:0] shadow [256];
    logic [31:0] rs = 32'd56932;
    int error_cnt = 0, comparisons = 0, l0, l1;
    emas_sequencer emas_sequencer_i (.*);
    emas_mem_model emas_mem_model_i (.*);
    always #10 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        regRd <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(posedge core_clk);
        check("regRdata", regRdata, e);
    endtask
    // offer one transaction, note its expected read data
    task automatic xact(input logic [1:0] b, input logic [3:0] w, input logic wr,
                        input logic [3:0] be, input logic [31:0] d);
        logic [31:0] e;
        e = 32'h0;
        for (int i = 0; i < 4; i++) begin
            if (be[i] && wr) shadow[{b, w, 2'(i)}] = d[8*i +: 8];
            if (be[i]) e[8*i +: 8] = shadow[{b, w, 2'(i)}];
        end
        expQ.push_back({wr, e});
        reqValid <= 1'b1; reqWrite <= wr; reqBytes <= be; reqWdata <= d;
        reqAddr <= {~b[1], b[0], 24'h0, w};
        do @(posedge core_clk); while (reqReady !== 1'b1);
    endtask
    task automatic drain(output int n);
        reqValid <= 1'b0;
        n = 0;
        while (expQ.size() != 0 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
    endtask
    task automatic lat_of(input logic [1:0] b, output int n);
        xact(b, 4'h1, 1'b0, 4'hf, 32'h0);
        drain(n);
        xact(b, 4'h1, 1'b0, 4'hf, 32'h0);
        drain(n);
    endtask
    // response watcher takes the oldest note
    always @(posedge core_clk) begin
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) check("spareRsp", 32'h1, 32'h0);
            else if (!expQ[0][32]) check("rspRdata", rspRdata, expQ[0][31:0]);
            if (expQ.size() != 0) void'(expQ.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        reg_wr(8'h04, 32'h1480055b);
        reg_wr(8'h08, 32'h0280046b);
        reg_rd(8'h00, emas_pkg::CfgResetVal);
        reg_rd(8'h04, 32'h1480055b);
        reg_rd(8'h40, 32'h0);
        reg_rd(8'h10, 32'h0);
        // every lane mask on 16-bit, 8-bit and short banks, back to back
        for (int m = 1; m < 16; m++) begin
            for (int b = 0; b < 3; b++) begin
                xact(2'(b), 4'(m), 1'b1, 4'(m), rnd());
                xact(2'(b), 4'(m), 1'b0, 4'hf, 32'h0);
                xact(2'(b), 4'(m), 1'b0, 4'(m), 32'h0);
            end
        end
        drain(l0);
        lat_of(2'h0, l0);
        stallTicks <= 8'd16;
        lat_of(2'h0, l1);
        check("stallLonger", {31'h0, l1 > l0}, 32'h1);
        lat_of(2'h2, l1);
        stallTicks <= 8'd0;
        lat_of(2'h2, l0);
        check("shortNoWait", 32'(l1), 32'(l0));
        give_verdict();
    end
endmodule
`default_nettype wire
